// File: instr_exec.sv
/*
  Executor for trap, OR, accumulator-to-file move, I/O-page moves,
  far jump/call and trap return.
  Assumes program memory returns op_word for pc within the same cycle;
  file and I/O-page registers are arrays inside this module.
*/
`timescale 1ns/1ps
`default_nettype none
module instr_exec
  import exec_pkg::*;
(
  input  wire logic            clk_sys,     // 40 MHz core clock
  input  wire logic            rst,         // Async reset, active high
  input  wire logic [OP_W-1:0] op_word,     // Opcode fetched at pc
  output logic      [PC_W-1:0] pc,          // Program counter
  output logic      [7:0]      accumulator, // Working register
  output logic                 zero_flag,   // Z status
  output logic                 global_irq_enable, // Interrupt enable
  output logic                 busy         // Multi-cycle op stalling
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  exec_state_e      state_ff, nxt_state;
  logic [1:0]       wait_ff, nxt_wait;
  logic [PC_W-1:0]  pc_ff, nxt_pc;
  logic [7:0]       acc_ff, nxt_acc;
  logic             z_ff, nxt_z;
  logic             gie_ff, nxt_gie;
  logic [SP_W-1:0]  sp_ff, nxt_sp;
  logic [PC_W-1:0]  stack_ff [STK_D];
  logic [7:0]       file_ff  [128];
  logic [7:0]       io_ff    [16];

  logic             push, file_we, io_we;
  logic [7:0]       file_wd, or_res;
  logic [6:0]       faddr;
  logic [3:0]       ioaddr;
  logic [PC_W-1:0]  pc_next_seq;

  function automatic logic io_ok(input logic [3:0] a);
    io_ok = (a >= IO_MIN) && (a <= IO_MAX);
  endfunction : io_ok

  assign faddr       = op_word[6:0];
  assign ioaddr      = op_word[3:0];
  assign pc_next_seq = pc_ff + 11'h001;

  // ----------------------------------------------------------------
  // Decode and execute
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_wait  = wait_ff;
    nxt_pc    = pc_ff;
    nxt_acc   = acc_ff;
    nxt_z     = z_ff;
    nxt_gie   = gie_ff;
    nxt_sp    = sp_ff;
    push      = 1'b0;
    file_we   = 1'b0;
    io_we     = 1'b0;
    file_wd   = acc_ff;
    or_res    = 8'h00;
    case (state_ff)
      ST_RUN: begin
        nxt_pc = pc_next_seq;
        if (op_word == TRAP_CODE) begin
          push      = 1'b1;
          nxt_sp    = sp_ff + 3'h1;
          nxt_pc    = TRAP_VEC;
          nxt_state = ST_WAIT;
          nxt_wait  = TRAP_CYC - 2'h1;
        end else if (op_word == TRET_CODE) begin
          nxt_sp    = sp_ff - 3'h1;
          nxt_pc    = stack_ff[sp_ff - 3'h1];
          nxt_gie   = 1'b1;
          nxt_state = ST_WAIT;
          nxt_wait  = BRANCH_CYC - 2'h1;
        end else if (op_word[13:11] == JMP_HI) begin
          nxt_pc    = op_word[10:0];
          nxt_state = ST_WAIT;
          nxt_wait  = BRANCH_CYC - 2'h1;
        end else if (op_word[13:11] == CALL_HI) begin
          push      = 1'b1;
          nxt_sp    = sp_ff + 3'h1;
          nxt_pc    = op_word[10:0];
          nxt_state = ST_WAIT;
          nxt_wait  = BRANCH_CYC - 2'h1;
        end else if (op_word[13:8] == ORLIT_HI) begin
          or_res  = acc_ff | op_word[7:0];
          nxt_acc = or_res;
          nxt_z   = (or_res == 8'h00);
        end else if (op_word[13:8] == ORFILE_HI) begin
          or_res = acc_ff | file_ff[faddr];
          nxt_z  = (or_res == 8'h00);
          if (op_word[7]) begin
            file_we = 1'b1;
            file_wd = or_res;
          end else begin
            nxt_acc = or_res;
          end
        end else if (op_word[13:7] == MOVAF_HI) begin
          file_we = 1'b1;
        end else if (op_word[13:4] == IO_PAGE_STORE_OP_HI) begin
          io_we = io_ok(ioaddr);
        end else if (op_word[13:4] == IOLD_HI) begin
          if (io_ok(ioaddr)) begin
            nxt_acc = io_ff[ioaddr];
          end
        end
      end
      ST_WAIT: begin
        // Fetched word is discarded while the pipeline refills
        nxt_wait = wait_ff - 2'h1;
        if (wait_ff == 2'h1) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ST_RUN;
      wait_ff  <= 2'h0;
      pc_ff    <= PC_RST;
      acc_ff   <= ACC_RST;
      z_ff     <= 1'b0;
      gie_ff   <= 1'b0;
      sp_ff    <= 3'h0;
    end else begin
      state_ff <= nxt_state;
      wait_ff  <= nxt_wait;
      pc_ff    <= nxt_pc;
      acc_ff   <= nxt_acc;
      z_ff     <= nxt_z;
      gie_ff   <= nxt_gie;
      sp_ff    <= nxt_sp;
    end
  end

  // ----------------------------------------------------------------
  // Storage arrays (no reset, like RAM)
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (push) begin
      stack_ff[sp_ff] <= pc_next_seq;
    end
    if (file_we) begin
      file_ff[faddr] <= file_wd;
    end
    if (io_we) begin
      io_ff[ioaddr] <= acc_ff;
    end
  end

  assign pc                = pc_ff;
  assign accumulator       = acc_ff;
  assign zero_flag         = z_ff;
  assign global_irq_enable = gie_ff;
  assign busy              = (state_ff == ST_WAIT);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic run;
  assign run = (state_ff == ST_RUN);

  trap_vector_a: assert property (@(posedge clk_sys) disable iff (rst)
    run && op_word == TRAP_CODE |=> pc == TRAP_VEC && busy ##1 busy ##1 !busy
      && $stable(zero_flag))
    else $error("trap did not vector or wrong cycles");
  or_lit_a: assert property (@(posedge clk_sys) disable iff (rst)
    run && op_word[13:8] == ORLIT_HI |=>
      accumulator == ($past(accumulator) | $past(op_word[7:0])))
    else $error("or literal result wrong");
  or_file_dest_a: assert property (@(posedge clk_sys) disable iff (rst)
    run && op_word[13:8] == ORFILE_HI && op_word[7] |=> $stable(accumulator))
    else $error("or to file changed accumulator");
  io_store_a: assert property (@(posedge clk_sys) disable iff (rst)
    run && op_word[13:4] == IO_PAGE_STORE_OP_HI |=> $stable(zero_flag) && $stable(accumulator))
    else $error("io store touched flags");
  io_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    run && op_word[13:4] == IOLD_HI |=> $stable(zero_flag) && !busy)
    else $error("io load touched zero flag");
  far_jump_a: assert property (@(posedge clk_sys) disable iff (rst)
    run && op_word[13:11] == JMP_HI |=> pc == $past(op_word[10:0]) && busy
      ##1 !busy && pc == $past(pc))
    else $error("far jump wrong");
  far_call_a: assert property (@(posedge clk_sys) disable iff (rst)
    run && op_word[13:11] == CALL_HI |=> sp_ff == $past(sp_ff) + 3'h1
      && stack_ff[$past(sp_ff)] == $past(pc) + 11'h001)
    else $error("far call did not push");
  move_file_a: assert property (@(posedge clk_sys) disable iff (rst)
    run && op_word[13:7] == MOVAF_HI |=> $stable(accumulator) && $stable(zero_flag))
    else $error("move to file changed state");
  trap_ret_a: assert property (@(posedge clk_sys) disable iff (rst)
    run && op_word == TRET_CODE |=> global_irq_enable && sp_ff == $past(sp_ff) - 3'h1)
    else $error("trap return wrong");
  zero_rule_a: assert property (@(posedge clk_sys) disable iff (rst)
    run && op_word[13:8] == ORLIT_HI |=> zero_flag == (accumulator == 8'h00))
    else $error("zero flag mismatch");

  trap_seen_c: cover property (@(posedge clk_sys) disable iff (rst)
    run && op_word == TRAP_CODE ##3 run && op_word == TRET_CODE);
  call_seen_c: cover property (@(posedge clk_sys) disable iff (rst)
    run && op_word[13:11] == CALL_HI);
  or_zero_c: cover property (@(posedge clk_sys) disable iff (rst)
    run && op_word[13:8] == ORFILE_HI ##1 zero_flag);

endmodule : instr_exec
`default_nettype wire

// File: exec_pkg.sv
/*
  Constants for the branch, logic and I/O-page instruction executor:
  opcode encodings, field positions, cycle counts and reset values.
  Assumes a 14-bit instruction word from program memory, one per fetch.
*/
package exec_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W   = 11;
  localparam int OP_W   = 14;
  localparam int STK_D  = 8;
  localparam int SP_W   = 3;

  // ----------------------------------------------------------------
  // Opcode encodings (chosen)
  // ----------------------------------------------------------------
  localparam logic [13:0] TRAP_CODE   = 14'h0001;
  localparam logic [13:0] TRET_CODE   = 14'h0002;
  localparam logic [5:0]  ORLIT_HI    = 6'h28;   // [13:8]
  localparam logic [5:0]  ORFILE_HI   = 6'h03;   // [13:8], d in [7]
  localparam logic [6:0]  MOVAF_HI    = 7'h01;   // [13:7]
  localparam logic [9:0]  IO_PAGE_STORE_OP_HI     = 10'h004; // [13:4]
  localparam logic [9:0]  IOLD_HI     = 10'h005; // [13:4]
  localparam logic [2:0]  JMP_HI      = 3'h6;    // [13:11]
  localparam logic [2:0]  CALL_HI     = 3'h7;    // [13:11]

  // ----------------------------------------------------------------
  // Operand limits, vectors, cycle counts, reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]    IO_MIN      = 4'h5;
  localparam logic [3:0]    IO_MAX      = 4'hf;
  localparam logic [PC_W-1:0] TRAP_VEC  = 11'h001;
  localparam logic [PC_W-1:0] PC_RST    = 11'h000;
  localparam logic [1:0]    TRAP_CYC    = 2'h3;
  localparam logic [1:0]    BRANCH_CYC  = 2'h2;
  localparam logic [7:0]    ACC_RST     = 8'h00;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_WAIT = 2'b01
  } exec_state_e;

endpackage : exec_pkg

// File: testbench.sv
/*
  Self-checking bench for instr_exec: a table of one-cycle ops, then
  branch, trap, return and reset cases written by hand.
  Assumes the chosen encodings of exec_pkg and results one cycle later.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import exec_pkg::*;
;
  typedef struct packed {
    logic [OP_W-1:0] op;
    logic [7:0]      acc;
    logic            z;
  } row_s;

  logic            clk_sys = 1'b0;
  logic            rst     = 1'b1;
  logic [OP_W-1:0] op_word = 14'h0000;
  logic [PC_W-1:0] pc;
  logic [7:0]      accumulator;
  logic            zero_flag;
  logic            global_irq_enable;
  logic            busy;
  int              mismatches = 0;
  int              compares   = 0;
  int              cyc;
  logic [PC_W-1:0] epc;
  row_s            rows [19] = '{
    '{14'h0045, 8'h00, 1'b0}, '{14'h0080, 8'h00, 1'b0}, '{14'h2800, 8'h00, 1'b1},
    '{14'h2855, 8'h55, 1'b0}, '{14'h0380, 8'h55, 1'b0}, '{14'h28aa, 8'hff, 1'b0},
    '{14'h0055, 8'h00, 1'b0}, '{14'h0300, 8'h55, 1'b0}, '{14'h0046, 8'h55, 1'b0},
    '{14'h0055, 8'h00, 1'b0}, '{14'h2800, 8'h00, 1'b1}, '{14'h0056, 8'h55, 1'b1},
    '{14'h0080, 8'h55, 1'b1}, '{14'h0380, 8'h55, 1'b0},
    // Load below index 5 is refused; then OR into a file register that gives zero
    '{14'h0052, 8'h55, 1'b0}, '{14'h0055, 8'h00, 1'b0}, '{14'h0081, 8'h00, 1'b0},
    '{14'h0381, 8'h00, 1'b1}, '{14'h2855, 8'h55, 1'b0}};

  always #12.5 clk_sys = ~clk_sys;

  instr_exec i_instr_exec (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .op_word           (op_word),
    .pc                (pc),
    .accumulator       (accumulator),
    .zero_flag         (zero_flag),
    .global_irq_enable (global_irq_enable),
    .busy              (busy)
  );

  // ----------------------------------------------------------------
  // Compare and drive tasks
  // ----------------------------------------------------------------
  task automatic chk_pc(input string nm, input logic [PC_W-1:0] e, input logic [PC_W-1:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_pc

  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_num(input string nm, input int e, input int g);
    compares++;
    if (g != e) begin
      mismatches++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk_num

  // Issue one op at a falling edge, count cycles until busy drops
  task automatic exec(input logic [OP_W-1:0] op);
    op_word = op;
    cyc = 1;
    @(negedge clk_sys);
    while (busy === 1'b1 && cyc < 8) begin
      @(negedge clk_sys);
      cyc++;
    end
  endtask : exec

  task automatic branch(input logic [OP_W-1:0] op, input logic [PC_W-1:0] e, input int n,
                        input logic g);
    exec(op);
    chk_pc("pc", e, pc);
    chk_num("cycles", n, cyc);
    chk_bit("gie", g, global_irq_enable);
    chk_byte("acc", 8'h55, accumulator);
    chk_bit("zero", 1'b0, zero_flag);
    $display("test op %h done", op);
  endtask : branch

  task automatic reset_check();
    chk_pc("pc", PC_RST, pc);
    chk_byte("acc", ACC_RST, accumulator);
    chk_bit("zero", 1'b0, zero_flag);
    chk_bit("gie", 1'b0, global_irq_enable);
    chk_bit("busy", 1'b0, busy);
    $display("test reset done");
  endtask : reset_check

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk_sys);
    reset_check();
    rst = 1'b0;
    epc = PC_RST;
    foreach (rows[i]) begin
      exec(rows[i].op);
      epc = epc + 11'h001;
      chk_pc("pc", epc, pc);
      chk_byte("acc", rows[i].acc, accumulator);
      chk_bit("zero", rows[i].z, zero_flag);
      chk_num("cycles", 1, cyc);
      $display("test row %0d done", i);
    end
    branch(14'h33a0, 11'h3a0, 2, 1'b0);
    branch(14'h3923, 11'h123, 2, 1'b0);
    branch(14'h0001, 11'h001, 3, 1'b0);
    branch(14'h0002, 11'h124, 2, 1'b1);
    branch(14'h0002, 11'h3a1, 2, 1'b1);
    branch(14'h37ff, 11'h7ff, 2, 1'b1);
    rst = 1'b1;
    @(negedge clk_sys);
    reset_check();
    tally_and_finish();
  end

  initial begin
    #(25 * 400);
    mismatches++;
    tally_and_finish();
  end

endmodule : testbench
`default_nettype wire
